/* rtim_pkg.sv */
// Package for the sixteen-bit reload timer: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave with one byte-wide register per aligned word.
package rtim_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CSR_UPPER = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CSR_LOWER = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT_UPPER = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CNT_LOWER = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_RLD_UPPER = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_RLD_LOWER = 5'h14;
  // Upper control status fields
  localparam int CSL_LSB = 3;
  localparam int MOD_LSB = 0;
  localparam logic [2:0] CSL_EVENT = 3'h7;
  localparam logic [2:0] MOD_PIN_OFF = 3'h0;
  // Lower control status fields
  localparam int BIT_TRG = 0;
  localparam int BIT_COUNT_ENABLE_BIT = 1;
  localparam int BIT_UF = 2;
  localparam int BIT_UNDERFLOW_IRQ_ENABLE = 3;
  localparam int BIT_RELOAD_SELECT_BIT = 4;
  localparam int BIT_OUTL = 5;
  localparam int BIT_OUTPUT_ENABLE_BIT = 6;
  localparam logic [7:0] CSRH_RESET = 8'h00;
  localparam logic [7:0] CSRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] RLD_RESET = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Internal count clock divisors selected by the clock select field
  localparam int PRESC_W = 7;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } cnt_state_t;
endpackage

/* rtim_pin_sync.sv */
// Two-stage synchroniser for the external input pin with edge detection.
// Assumes the pin is asynchronous to CLK.
`timescale 1ns/1ps
module rtim_pin_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule

/* rtim_top.sv */
// Sixteen-bit down-counting reload timer with APB register access.
// Assumes APB master on CLK; the input pin is asynchronous and is synchronised here.
// What this block does
// - One-shot internal mode: trigger or valid pin edge loads reload value and counts down.
// - Writing count enable and software trigger together starts counting at once.
// - Reload select zero: underflow stops counter holding all ones, both modes.
// - Underflow sets underflow flag; interrupt raised while flag and enable are one.
// - One-shot internal mode drives square wave on output pin while counting.
// - Trigger edge rising, falling or both chosen by operating mode field.
// - Gate mode: software start, decrement only while selected pin level present.
// - Event mode decrements once per valid pin edge; interrupt on underflow.
// - Event mode loads reload value on count enable plus software trigger.
// - Event mode with reload select one reloads on underflow and keeps counting.
// - Event mode sets underflow flag every underflow; interrupt when enabled.
// - Event reload mode toggles output pin at every underflow.
// - Event one-shot mode drives square wave showing counting in progress.
// - Control, count and reload visible as six byte-wide registers.
// - Clock select all ones selects event count mode; others internal clock.
// - Operating mode zero ignores input pin; only software trigger starts.
// - Internal mode: mode top bit makes gate input, low bit picks level.
// - Output enable hands output pin to timer waveform regardless of port direction.
`timescale 1ns/1ps
module rtim_top
  import rtim_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_IN,
  output logic TMR_OUT,
  output logic TMR_OUT_EN_N,
  output logic IRQ
);
  import rtim_pkg::*;

  logic [7:0] csr_upper_ff;
  logic [7:0] csr_lower_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic [PRESC_W-1:0] presc_prev_ff;
  logic toggle_ff;
  cnt_state_t state_ff;
  cnt_state_t nxt_state;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [ADDR_W-1:0] offset;
  logic sw_trig;
  logic [2:0] clk_sel;
  logic [2:0] op_mode;
  logic event_mode;
  logic gate_mode;
  logic pin_edge;
  logic ext_trig;
  logic start;
  logic int_tick;
  logic count_tick;
  logic underflow;
  logic stop_count_enable_bit;
  logic count_enable_bit_next;
  logic load;

  // Single synchroniser keeps each pin transition counted once
  rtim_pin_sync u_sync
  (
    .clk(CLK),
    .rst(RST),
    .pin_in(EXT_IN),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // APB decode; zero-wait-state slave
  assign offset = PADDR[ADDR_W-1:0];
  assign addr_hit = (PADDR[31:ADDR_W] == '0) &&
                    (offset == OFF_CSR_UPPER || offset == OFF_CSR_LOWER ||
                     offset == OFF_CNT_UPPER || offset == OFF_CNT_LOWER ||
                     offset == OFF_RLD_UPPER || offset == OFF_RLD_LOWER);
  assign wr_en = PSEL & PENABLE & PWRITE & PSTRB[0] & addr_hit;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;

  assign clk_sel = csr_upper_ff[CSL_LSB +: 3];
  assign op_mode = csr_upper_ff[MOD_LSB +: 3];
  assign event_mode = (clk_sel == CSL_EVENT);
  assign gate_mode = ~event_mode & op_mode[2];

  // Edge selection from the low mode bits; mode zero disables the pin
  always_comb
  begin
    case (op_mode[1:0])
      2'h1: pin_edge = pin_rise;
      2'h2: pin_edge = pin_fall;
      2'h3: pin_edge = pin_rise | pin_fall;
      default: pin_edge = 1'b0;
    endcase
  end

  // Pin triggers only in internal trigger mode; event mode starts from software
  assign ext_trig = ~event_mode & ~gate_mode & pin_edge;
  assign sw_trig = wr_en && offset == OFF_CSR_LOWER && PWDATA[BIT_TRG];
  assign count_enable_bit_next = (wr_en && offset == OFF_CSR_LOWER) ? PWDATA[BIT_COUNT_ENABLE_BIT]
                                                        : csr_lower_ff[BIT_COUNT_ENABLE_BIT];
  // Same-access count enable plus trigger starts immediately
  assign start = count_enable_bit_next & (sw_trig | ext_trig);
  assign stop_count_enable_bit = ~count_enable_bit_next;

  // Prescaler: select 0 counts every clock, then divide by powers of two
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      presc_ff <= '0;
      presc_prev_ff <= '0;
    end
    else
    begin
      presc_ff <= presc_ff + 1'b1;
      presc_prev_ff <= presc_ff;
    end
  end

  always_comb
  begin
    case (clk_sel)
      3'h0: int_tick = 1'b1;
      3'h1: int_tick = presc_prev_ff[0] & ~presc_ff[0];
      3'h2: int_tick = presc_prev_ff[1] & ~presc_ff[1];
      3'h3: int_tick = presc_prev_ff[2] & ~presc_ff[2];
      3'h4: int_tick = presc_prev_ff[3] & ~presc_ff[3];
      3'h5: int_tick = presc_prev_ff[4] & ~presc_ff[4];
      3'h6: int_tick = presc_prev_ff[6] & ~presc_ff[6];
      default: int_tick = 1'b0;
    endcase
  end

  // Gate mode counts only at the chosen level; event mode counts pin edges
  always_comb
  begin
    if (event_mode)
      count_tick = pin_edge;
    else if (gate_mode)
      count_tick = int_tick & (pin_level == op_mode[0]);
    else
      count_tick = int_tick;
  end

  assign load = start;
  assign underflow = (state_ff == ST_RUN) & ~load & count_tick & (count_ff == CNT_ZERO);

  always_comb
  begin
    case (state_ff)
      ST_STOP: nxt_state = start ? ST_RUN : (count_enable_bit_next ? ST_WAIT : ST_STOP);
      ST_WAIT: nxt_state = stop_count_enable_bit ? ST_STOP : (start ? ST_RUN : ST_WAIT);
      ST_RUN:
      begin
        if (stop_count_enable_bit)
          nxt_state = ST_STOP;
        else if (start)
          nxt_state = ST_RUN;
        else if (underflow && !csr_lower_ff[BIT_RELOAD_SELECT_BIT])
          nxt_state = ST_WAIT;
        else
          nxt_state = ST_RUN;
      end
      default: nxt_state = ST_STOP;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_ff <= ST_STOP;
    else
      state_ff <= nxt_state;
  end

  // Counter: load on start, reload on underflow when reload select is set
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      count_ff <= CNT_RESET;
    else if (load)
      count_ff <= reload_ff;
    else if (underflow && csr_lower_ff[BIT_RELOAD_SELECT_BIT])
      count_ff <= reload_ff;
    else if (underflow)
      count_ff <= CNT_ALL_ONES;
    else if (state_ff == ST_RUN && count_tick)
      count_ff <= count_ff - 1'b1;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      reload_ff <= RLD_RESET;
    else if (wr_en && offset == OFF_RLD_UPPER)
      reload_ff[15:8] <= PWDATA[7:0];
    else if (wr_en && offset == OFF_RLD_LOWER)
      reload_ff[7:0] <= PWDATA[7:0];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      csr_upper_ff <= CSRH_RESET;
    else if (wr_en && offset == OFF_CSR_UPPER)
      csr_upper_ff <= {2'b00, PWDATA[5:0]};
  end

  // Lower control: the trigger bit is write-only and never stored.
  // Software may only clear the underflow flag; a same-cycle underflow wins.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      csr_lower_ff <= CSRL_RESET;
    else
    begin
      if (wr_en && offset == OFF_CSR_LOWER)
      begin
        csr_lower_ff[7] <= 1'b0;
        csr_lower_ff[BIT_OUTPUT_ENABLE_BIT] <= PWDATA[BIT_OUTPUT_ENABLE_BIT];
        csr_lower_ff[BIT_OUTL] <= PWDATA[BIT_OUTL];
        csr_lower_ff[BIT_RELOAD_SELECT_BIT] <= PWDATA[BIT_RELOAD_SELECT_BIT];
        csr_lower_ff[BIT_UNDERFLOW_IRQ_ENABLE] <= PWDATA[BIT_UNDERFLOW_IRQ_ENABLE];
        csr_lower_ff[BIT_COUNT_ENABLE_BIT] <= PWDATA[BIT_COUNT_ENABLE_BIT];
        csr_lower_ff[BIT_TRG] <= 1'b0;
      end
      if (underflow)
        csr_lower_ff[BIT_UF] <= 1'b1;
      else if (wr_en && offset == OFF_CSR_LOWER && !PWDATA[BIT_UF])
        csr_lower_ff[BIT_UF] <= 1'b0;
    end
  end

  // Toggle output inverts on every underflow and restarts low on a start from stop or wait, not on a retrigger while running
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      toggle_ff <= 1'b0;
    else if (start && state_ff != ST_RUN)
      toggle_ff <= 1'b0;
    else if (underflow)
      toggle_ff <= ~toggle_ff;
  end

  // Output pin: square while running in one-shot, toggle in reload; level select inverts
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      TMR_OUT <= 1'b0;
      TMR_OUT_EN_N <= 1'b1;
    end
    else
    begin
      if (csr_lower_ff[BIT_RELOAD_SELECT_BIT])
        TMR_OUT <= toggle_ff ^ csr_lower_ff[BIT_OUTL];
      else
        TMR_OUT <= (state_ff == ST_RUN) ^ csr_lower_ff[BIT_OUTL];
      TMR_OUT_EN_N <= ~csr_lower_ff[BIT_OUTPUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= csr_lower_ff[BIT_UF] & csr_lower_ff[BIT_UNDERFLOW_IRQ_ENABLE];
  end

  // Six byte-wide registers in the low byte of each word
  always_comb
  begin
    PRDATA = 32'h00000000;
    if (rd_en)
    begin
      case (offset)
        OFF_CSR_UPPER: PRDATA[7:0] = csr_upper_ff;
        OFF_CSR_LOWER: PRDATA[7:0] = {1'b0, csr_lower_ff[6:1], 1'b0};
        OFF_CNT_UPPER: PRDATA[7:0] = count_ff[15:8];
        OFF_CNT_LOWER: PRDATA[7:0] = count_ff[7:0];
        OFF_RLD_UPPER: PRDATA[7:0] = reload_ff[15:8];
        OFF_RLD_LOWER: PRDATA[7:0] = reload_ff[7:0];
        default: PRDATA = 32'h00000000;
      endcase
    end
  end
endmodule

/* rtim_chk.sv */
// Port-level checker for the reload timer: bus decode, output pin and interrupt timing.
// Assumes it is bound to rtim_top and sees only the top module's ports.
`timescale 1ns/1ps
module rtim_chk
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TMR_OUT,
  input wire logic TMR_OUT_EN_N,
  input wire logic IRQ
);
  logic acc;
  logic mapped;
  logic wr_low;
  assign acc = PSEL && PENABLE;
  assign mapped = PADDR inside {32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14};
  assign wr_low = acc && PWRITE && PSTRB[0] && PADDR == 32'h4;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Output pin lags the control write by two edges: state, then pin register
  sequence s_start;
    wr_low && PWDATA[1:0] == 2'b11 && !PWDATA[4];
  endsequence
  sequence s_stop;
    wr_low && !PWDATA[1] && !PWDATA[4];
  endsequence
  a_ready_high: assert property (PSEL |-> PREADY) else $error("ready low");
  a_err_decode: assert property (acc |-> PSLVERR == !mapped) else $error("bad err");
  a_rdata_width: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_trig_reads0: assert property (acc && !PWRITE && PADDR == 32'h4 |-> !PRDATA[0])
    else $error("trigger bit reads one");
  a_oe_follows: assert property (wr_low |-> ##2 TMR_OUT_EN_N == !$past(PWDATA[6], 2))
    else $error("output enable wrong");
  // IRQ is registered from the flag, so the cleared enable shows two edges after the write
  a_irq_masked: assert property (wr_low && !PWDATA[3] |-> ##2 !IRQ [*2])
    else $error("irq while masked");
  a_start_square: assert property (s_start |-> ##2 TMR_OUT == !$past(PWDATA[5], 2))
    else $error("no square at start");
  a_stop_level: assert property (s_stop |-> ##2 TMR_OUT == $past(PWDATA[5], 2))
    else $error("pin not idle after stop");
endmodule

bind rtim_top rtim_chk rtim_chk_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TMR_OUT(TMR_OUT), .TMR_OUT_EN_N(TMR_OUT_EN_N), .IRQ(IRQ));

/* rtim_src.sv */
// Behavioural pulse, trigger and gate source for the timer input pin.
// Assumes commands on clk; the pin idles low and pulses high for whole cycles.
`timescale 1ns/1ps
module rtim_src
(
  input wire logic clk,
  input wire logic go,
  input wire logic [5:0] width,
  input wire logic [3:0] num,
  output logic pin,
  output logic busy
);
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Edges stay width cycles apart so each survives the synchroniser
  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      repeat (num)
      begin
        pin <= 1'b1;
        repeat (width) @(posedge clk);
        pin <= 1'b0;
        repeat (width) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

/* tb_rtim_top.sv */
// Self-checking bench for the reload timer: APB master, read scoreboard, pulse source.
// Assumes rtim_top with the checker bound and rtim_src on the input pin.
`timescale 1ns/1ps
module tb_rtim_top;
  import rtim_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tmr_out, tmr_out_en_n, irq, ext_in, src_busy;
  logic go = 1'b0;
  logic [5:0] width = 6'h4;
  logic [3:0] num = 4'h1;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  rtim_top rtim_top_i (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_IN(ext_in), .TMR_OUT(tmr_out), .TMR_OUT_EN_N(tmr_out_en_n), .IRQ(irq));
  rtim_src rtim_src_i (.clk(clk), .go(go), .width(width), .num(num), .pin(ext_in),
    .busy(src_busy));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(bit ok, string msg);
    num_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic hang(bit stuck, string msg);
    if (stuck)
    begin
      check(1'b0, msg);
      end_sim();
    end
  endtask
  task automatic apb(bit wr, logic [31:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    hang(i == 50, "bus timeout");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // The read data is taken at the same edge that ends the access phase
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      check(prdata === exp_q.pop_front(), "read data");
  task automatic wait_irq(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while (irq !== 1'b1 && cnt < 300);
    hang(irq !== 1'b1, "no interrupt");
  endtask
  task automatic pulse(logic [5:0] w, logic [3:0] k);
    width <= w;
    num <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic wait_src();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (src_busy !== 1'b0 && i < 600);
    hang(src_busy !== 1'b0, "source stuck");
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    logic [15:0] r;
    logic [15:0] r2;
    int cnt;
    void'($urandom(32'h295a833c));
    r = 16'(4 + $urandom_range(11));
    r2 = 16'(2 + $urandom_range(3));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(32'(4 * i), 32'h0);
    apb(1'b1, 32'h10, 32'h0);
    apb(1'b1, 32'h14, 32'(r));
    apb(1'b1, 32'h0c, 32'h5a);
    rd(32'h14, 32'(r));
    rd(32'h0c, 32'h0);
    $display("Test registers done");
    apb(1'b1, 32'h4, 32'h4b);
    wait_irq(cnt);
    check(cnt == r + 3, "software one-shot length");
    rd(32'h08, 32'hff);
    rd(32'h0c, 32'hff);
    rd(32'h04, 32'h4e);
    check(tmr_out === 1'b0, "pin high after halt");
    pulse(6'd32, 4'h1);
    wait_src();
    rd(32'h0c, 32'hff);
    $display("Test software one-shot done");
    for (int m = 1; m < 4; m++)
    begin
      apb(1'b1, 32'h0, 32'(m));
      apb(1'b1, 32'h4, 32'h4a);
      repeat (2) @(posedge clk);
      pulse(6'd32, 4'h1);
      wait_irq(cnt);
      check(cnt == r + (m == 2 ? 38 : 6), "edge trigger timing");
      if (m == 3)
      begin
        apb(1'b1, 32'h4, 32'h4a);
        repeat (2) @(posedge clk);
        wait_irq(cnt);
      end
      wait_src();
    end
    $display("Test edge triggers done");
    apb(1'b1, 32'h0, 32'h05);
    apb(1'b1, 32'h4, 32'h4b);
    repeat (10) @(posedge clk);
    rd(32'h0c, 32'(r));
    pulse(6'd32, 4'h1);
    wait_irq(cnt);
    wait_src();
    rd(32'h0c, 32'hff);
    // Clear the flag first so the low-level run starts with the interrupt idle
    apb(1'b1, 32'h4, 32'h4a);
    apb(1'b1, 32'h0, 32'h04);
    apb(1'b1, 32'h4, 32'h4b);
    wait_irq(cnt);
    check(cnt == r + 3, "gate low level");
    $display("Test gate done");
    apb(1'b1, 32'h0, 32'h39);
    apb(1'b1, 32'h14, 32'(r2));
    apb(1'b1, 32'h4, 32'h5b);
    pulse(6'd4, 4'(r2 + 1));
    wait_src();
    rd(32'h00, 32'h39);
    rd(32'h0c, 32'(r2));
    rd(32'h04, 32'h5e);
    check(irq === 1'b1, "event interrupt");
    check(tmr_out === 1'b1, "toggle after underflow");
    apb(1'b1, 32'h4, 32'h4b);
    repeat (3) @(posedge clk);
    check(tmr_out === 1'b1, "square while counting");
    pulse(6'd4, 4'(r2 + 1));
    wait_src();
    rd(32'h0c, 32'hff);
    check(tmr_out === 1'b0, "square after halt");
    apb(1'b1, 32'h4, 32'h0);
    repeat (4) @(posedge clk);
    $display("Test event count done");
    end_sim();
  end
endmodule
